// ==== rtl/compress_pkg.sv ====
package compress_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // base instruction opcodes
  localparam logic [6:0] OP_LOAD = 7'h03;
  localparam logic [6:0] OP_LOAD_FP = 7'h07;
  localparam logic [6:0] OP_MISC_MEM = 7'h0f;
  localparam logic [6:0] OP_IMM = 7'h13;
  localparam logic [6:0] OP_IMM_32 = 7'h1b;
  localparam logic [6:0] OP_STORE = 7'h23;
  localparam logic [6:0] OP_STORE_FP = 7'h27;
  localparam logic [6:0] OP_LUI = 7'h37;
  localparam logic [6:0] OP_BRANCH = 7'h63;
  localparam logic [6:0] OP_JALR = 7'h67;
  localparam logic [6:0] OP_JAL = 7'h6f;

  // minor opcode field values of the base encodings
  localparam logic [2:0] F3_ADD = 3'h0;
  localparam logic [2:0] F3_SLL = 3'h1;
  localparam logic [2:0] F3_WORD = 3'h2;
  localparam logic [2:0] F3_DOUBLE = 3'h3;
  localparam logic [2:0] F3_QUAD_LD = 3'h2;
  localparam logic [2:0] F3_QUAD_ST = 3'h4;
  localparam logic [2:0] F3_SRL = 3'h5;
  localparam logic [2:0] F3_AND = 3'h7;
  localparam logic [2:0] F3_EQ = 3'h0;
  localparam logic [2:0] F3_NE = 3'h1;

  // fixed register numbers
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_LINK = 5'h01;
  localparam logic [4:0] REG_STACK = 5'h02;
  localparam logic [1:0] CMP_REG_HIGH = 2'h1;

  // shift encodings and fixed words
  localparam logic [4:0] SHIFT_ARITH = 5'h08;
  localparam logic [4:0] SHIFT_LOGIC = 5'h00;
  localparam logic [6:0] SHIFT_64 = 7'h40;
  localparam logic [31:0] BREAK_WORD = 32'h0010_0073;

  // quadrant and minor opcode keys of the compact space
  localparam logic [4:0] KEY_STACK_POINTER_OFFSET = 5'h00;
  localparam logic [4:0] KEY_LOAD_DOUBLE_QUAD = 5'h01;
  localparam logic [4:0] KEY_LOAD_WORD = 5'h02;
  localparam logic [4:0] KEY_LOAD_SINGLE_DOUBLE = 5'h03;
  localparam logic [4:0] KEY_Q0_RESERVED = 5'h04;
  localparam logic [4:0] KEY_STORE_DOUBLE_QUAD = 5'h05;
  localparam logic [4:0] KEY_STORE_WORD = 5'h06;
  localparam logic [4:0] KEY_STORE_SINGLE_DOUBLE = 5'h07;
  localparam logic [4:0] KEY_ADD_IMMEDIATE = 5'h08;
  localparam logic [4:0] KEY_LINK_OR_WORD_ADD = 5'h09;
  localparam logic [4:0] KEY_LOAD_IMMEDIATE = 5'h0a;
  localparam logic [4:0] KEY_UPPER_OR_STACK = 5'h0b;
  localparam logic [4:0] KEY_MISC_ALU = 5'h0c;
  localparam logic [4:0] KEY_JUMP = 5'h0d;
  localparam logic [4:0] KEY_BRANCH_IF_ZERO = 5'h0e;
  localparam logic [4:0] KEY_BRANCH_IF_NONZERO = 5'h0f;
  localparam logic [4:0] KEY_SHIFT_LEFT = 5'h10;
  localparam logic [4:0] KEY_JUMP_REGISTER = 5'h14;

  // misc-alu sub operations in halfword bits 11:10
  localparam logic [1:0] ALU_SHIFT_RIGHT = 2'h0;
  localparam logic [1:0] ALU_SHIFT_ARITH = 2'h1;
  localparam logic [1:0] ALU_AND_IMM = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // result handed downstream
  typedef struct packed {
    logic [31:0] insn;
    logic [15:0] raw;
    logic compressed;
    logic illegal;
    logic hint;
    logic custom;
  } expand_result_s;

  localparam expand_result_s RESULT_RESET = '0;
  localparam logic VALID_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // base format packers
  function automatic logic [31:0] enc_i(input logic [11:0] imm, input logic [4:0] rs1,
                                        input logic [2:0] f3, input logic [4:0] rd,
                                        input logic [6:0] op);
    return {imm, rs1, f3, rd, op};
  endfunction : enc_i

  function automatic logic [31:0] enc_s(input logic [11:0] imm, input logic [4:0] rs2,
                                        input logic [4:0] rs1, input logic [2:0] f3,
                                        input logic [6:0] op);
    return {imm[11:5], rs2, rs1, f3, imm[4:0], op};
  endfunction : enc_s

  function automatic logic [31:0] enc_b(input logic [12:0] imm, input logic [4:0] rs1,
                                        input logic [2:0] f3);
    return {imm[12], imm[10:5], REG_ZERO, rs1, f3, imm[4:1], imm[11], OP_BRANCH};
  endfunction : enc_b

  function automatic logic [31:0] enc_j(input logic [20:0] imm, input logic [4:0] rd);
    return {imm[20], imm[10:1], imm[11], imm[19:12], rd, OP_JAL};
  endfunction : enc_j

  // compact three-bit register field to full register number
  function automatic logic [4:0] cmp_reg(input logic [2:0] r);
    return {CMP_REG_HIGH, r};
  endfunction : cmp_reg

endpackage : compress_pkg

// ==== rtl/expand_out_stage.sv ====
`timescale 1ns/10ps
module expand_out_stage (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // expanded word from the decode logic
  input wire logic in_valid,
  input compress_pkg::expand_result_s in_result,
  // registered result toward the decoder
  output logic out_valid,
  output compress_pkg::expand_result_s out_result
);

  ////////////////////////////////////////////////////////////////////////////
  // valid flag, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= compress_pkg::VALID_RESET;
    end else if (ce) begin
      out_valid <= in_valid;
    end
  end

  // result word only loads on a valid halfword so it holds between fetches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_result <= compress_pkg::RESULT_RESET;
    end else if (ce && in_valid) begin
      out_result <= in_result;
    end
  end

endmodule : expand_out_stage

// ==== rtl/compressed_insn_expander.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - word load adds offset times four to base register, loads into dest.
// - doubleword load only on 64/128-bit bases, offset scaled by eight.
// - quadword load only on 128-bit base, offset scaled by sixteen.
// - float loads: single on 32-bit with single support, double on 32/64.
// - word store writes source register at base plus offset times four.
// - doubleword store on 64/128-bit, quadword store only on 128-bit.
// - float stores: single on 32-bit base, double on 32/64-bit bases.
// - all control-transfer offsets count halfwords; their low bit is zero.
// - plain jump adds sign-extended offset to pc, link register x0.
// - jump-and-link only on 32-bit base, writes pc+2 into x1.
// - jump register goes to rs1 with x0 link; rs1 of x0 reserved.
// - jump-and-link register writes x1; rs1 of x0 is the breakpoint.
// - zero and nonzero branches compare the compact register against x0.
// - load immediate is add-immediate from x0; rd of x0 is a hint.
// - upper immediate fills bits 17-12; zero reserved, x0 hint, x2 stack.
// - add immediate to rd; rd x0 with zero immediate is no-op, any other x0 or zero-immediate form is hint.
// - word add immediate on 64/128-bit only; rd of x0 reserved.
// - stack adjust adds nonzero multiple of sixteen to x2; zero reserved.
// - stack pointer add writes x2 plus nonzero offset times four.
// - left shift: 128-bit zero means 64; custom, hint and x0 cases.
// - right shifts: 128-bit amount sign-extended, zero is 64; hints, custom.
// - and immediate with sign-extended six-bit value, result to rd'.
// - three-bit register fields select x8-x15 or f8-f15.
// - the all-zero halfword is always illegal.
module compressed_insn_expander #(
  parameter int unsigned base_width = 32,
  parameter bit has_single = 1'b1,
  parameter bit has_double = 1'b1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // halfword from the fetch stage
  input wire logic in_valid,
  input wire logic [15:0] in_halfword,
  // expanded word toward the decoder
  output logic out_valid,
  output compress_pkg::expand_result_s out_result
);

  localparam bit is_32 = (base_width == 32);
  localparam bit is_128 = (base_width == 128);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_n_q;

  // async assert, release through two flops; not frozen by ce so reset
  // always completes even while the pipeline is held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction

  logic [15:0] c;
  logic [1:0] quadrant;
  logic [2:0] minor_opcode_field;
  logic [4:0] key;
  logic [4:0] rd_full;
  logic [4:0] rs2_full;
  logic [4:0] compact_base_field;
  logic [4:0] compact_source_field;
  logic [5:0] ci_imm;

  assign c = in_halfword;
  assign quadrant = c[1:0];
  assign minor_opcode_field = c[15:13];
  assign key = {quadrant, minor_opcode_field};

  // full-size rd field sits where the base encodings keep it; rs2 field sits at bits 6:2
  assign rd_full = c[11:7];
  assign rs2_full = c[6:2];

  // compact fields map to the eight most used registers
  assign compact_base_field = compress_pkg::cmp_reg(c[9:7]);
  assign compact_source_field = compress_pkg::cmp_reg(c[4:2]);

  // six-bit immediate of the immediate format, sign bit at 12
  assign ci_imm = {c[12], c[6:2]};

  ////////////////////////////////////////////////////////////////////////////
  // immediates, unscrambled and scaled

  logic [11:0] off_word;
  logic [11:0] off_double;
  logic [11:0] off_quad;
  logic [11:0] off_stack_ptr;
  logic [11:0] off_stack_adj;
  logic [11:0] imm_sext;
  logic [20:0] off_jump;
  logic [12:0] off_branch;
  logic [19:0] upper_imm;

  // memory offsets are zero-extended; the low zeros do the scaling
  assign off_word = {5'h00, c[5], c[12:10], c[6], 2'h0};
  assign off_double = {4'h0, c[6:5], c[12:10], 3'h0};
  assign off_quad = {3'h0, c[10], c[6:5], c[12:11], 4'h0};
  assign off_stack_ptr = {2'h0, c[10:7], c[12:11], c[5], c[6], 2'h0};

  // stack adjust: multiples of sixteen from -512 to 496
  assign off_stack_adj = {{2{c[12]}}, c[12], c[4:3], c[5], c[2], c[6], 4'h0};

  // plain sign-extended six-bit immediate
  assign imm_sext = {{6{c[12]}}, ci_imm};

  // jump and branch offsets in halfword units, low bit forced zero
  assign off_jump = {{9{c[12]}}, c[12], c[8], c[10:9], c[6], c[7], c[2], c[11],
                     c[5:3], 1'b0};
  assign off_branch = {{4{c[12]}}, c[12], c[6:5], c[2], c[11:10], c[4:3], 1'b0};

  // bit 17 of the loaded constant sign-extends through the upper field
  assign upper_imm = {{14{c[12]}}, ci_imm};

  ////////////////////////////////////////////////////////////////////////////
  // shift amounts

  logic [6:0] shamt_left;
  logic [6:0] shamt_right;
  logic shamt_zero;

  assign shamt_zero = (ci_imm == 6'h00);

  // the wide base reuses zero as a shift of 64
  always_comb begin
    if (is_128 && shamt_zero) begin
      shamt_left = compress_pkg::SHIFT_64;
    end else begin
      shamt_left = {1'b0, ci_imm};
    end
  end

  // right shifts on the wide base sign-extend the amount: 1-31, 64, 96-127
  always_comb begin
    if (is_128 && shamt_zero) begin
      shamt_right = compress_pkg::SHIFT_64;
    end else if (is_128) begin
      shamt_right = {ci_imm[5], ci_imm};
    end else begin
      shamt_right = {1'b0, ci_imm};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expansion

  logic [31:0] insn;
  logic bad;
  logic hint;
  logic custom;

  // one case per quadrant and minor opcode; hints still expand as plain ops
  always_comb begin
    insn = 32'h0000_0000;
    bad = 1'b0;
    hint = 1'b0;
    custom = 1'b0;
    case (key)
      compress_pkg::KEY_STACK_POINTER_OFFSET: begin
        insn = compress_pkg::enc_i(off_stack_ptr, compress_pkg::REG_STACK,
                                   compress_pkg::F3_ADD, compact_source_field,
                                   compress_pkg::OP_IMM);
        bad = (off_stack_ptr == 12'h000);
      end
      compress_pkg::KEY_LOAD_DOUBLE_QUAD: begin
        if (is_128) begin
          insn = compress_pkg::enc_i(off_quad, compact_base_field, compress_pkg::F3_QUAD_LD,
                                     compact_source_field, compress_pkg::OP_MISC_MEM);
        end else begin
          insn = compress_pkg::enc_i(off_double, compact_base_field, compress_pkg::F3_DOUBLE,
                                     compact_source_field, compress_pkg::OP_LOAD_FP);
          bad = !has_double;
        end
      end
      compress_pkg::KEY_LOAD_WORD: begin
        insn = compress_pkg::enc_i(off_word, compact_base_field, compress_pkg::F3_WORD,
                                   compact_source_field, compress_pkg::OP_LOAD);
      end
      compress_pkg::KEY_LOAD_SINGLE_DOUBLE: begin
        if (is_32) begin
          insn = compress_pkg::enc_i(off_word, compact_base_field, compress_pkg::F3_WORD,
                                     compact_source_field, compress_pkg::OP_LOAD_FP);
          bad = !has_single;
        end else begin
          insn = compress_pkg::enc_i(off_double, compact_base_field, compress_pkg::F3_DOUBLE,
                                     compact_source_field, compress_pkg::OP_LOAD);
        end
      end
      compress_pkg::KEY_Q0_RESERVED: begin
        bad = 1'b1;
      end
      compress_pkg::KEY_STORE_DOUBLE_QUAD: begin
        if (is_128) begin
          insn = compress_pkg::enc_s(off_quad, compact_source_field, compact_base_field,
                                     compress_pkg::F3_QUAD_ST, compress_pkg::OP_STORE);
        end else begin
          insn = compress_pkg::enc_s(off_double, compact_source_field, compact_base_field,
                                     compress_pkg::F3_DOUBLE, compress_pkg::OP_STORE_FP);
          bad = !has_double;
        end
      end
      compress_pkg::KEY_STORE_WORD: begin
        insn = compress_pkg::enc_s(off_word, compact_source_field, compact_base_field,
                                   compress_pkg::F3_WORD, compress_pkg::OP_STORE);
      end
      compress_pkg::KEY_STORE_SINGLE_DOUBLE: begin
        if (is_32) begin
          insn = compress_pkg::enc_s(off_word, compact_source_field, compact_base_field,
                                     compress_pkg::F3_WORD, compress_pkg::OP_STORE_FP);
          bad = !has_single;
        end else begin
          insn = compress_pkg::enc_s(off_double, compact_source_field, compact_base_field,
                                     compress_pkg::F3_DOUBLE, compress_pkg::OP_STORE);
        end
      end
      compress_pkg::KEY_ADD_IMMEDIATE: begin
        insn = compress_pkg::enc_i(imm_sext, rd_full, compress_pkg::F3_ADD, rd_full,
                                   compress_pkg::OP_IMM);
        // rd x0 with zero immediate is the no-op, not a hint
        hint = (rd_full == compress_pkg::REG_ZERO) ? !shamt_zero : shamt_zero;
      end
      compress_pkg::KEY_LINK_OR_WORD_ADD: begin
        if (is_32) begin
          insn = compress_pkg::enc_j(off_jump, compress_pkg::REG_LINK);
        end else begin
          insn = compress_pkg::enc_i(imm_sext, rd_full, compress_pkg::F3_ADD, rd_full,
                                     compress_pkg::OP_IMM_32);
          bad = (rd_full == compress_pkg::REG_ZERO);
        end
      end
      compress_pkg::KEY_LOAD_IMMEDIATE: begin
        insn = compress_pkg::enc_i(imm_sext, compress_pkg::REG_ZERO, compress_pkg::F3_ADD,
                                   rd_full, compress_pkg::OP_IMM);
        hint = (rd_full == compress_pkg::REG_ZERO);
      end
      compress_pkg::KEY_UPPER_OR_STACK: begin
        if (rd_full == compress_pkg::REG_STACK) begin
          insn = compress_pkg::enc_i(off_stack_adj, compress_pkg::REG_STACK,
                                     compress_pkg::F3_ADD, compress_pkg::REG_STACK,
                                     compress_pkg::OP_IMM);
          bad = shamt_zero;
        end else begin
          insn = {upper_imm, rd_full, compress_pkg::OP_LUI};
          bad = shamt_zero;
          hint = (rd_full == compress_pkg::REG_ZERO);
        end
      end
      compress_pkg::KEY_MISC_ALU: begin
        case (c[11:10])
          compress_pkg::ALU_SHIFT_RIGHT, compress_pkg::ALU_SHIFT_ARITH: begin
            insn = compress_pkg::enc_i({c[10] ? compress_pkg::SHIFT_ARITH
                                              : compress_pkg::SHIFT_LOGIC, shamt_right},
                                       compact_base_field, compress_pkg::F3_SRL,
                                       compact_base_field, compress_pkg::OP_IMM);
            custom = is_32 && c[12];
            hint = !is_128 && shamt_zero;
          end
          compress_pkg::ALU_AND_IMM: begin
            insn = compress_pkg::enc_i(imm_sext, compact_base_field, compress_pkg::F3_AND,
                                       compact_base_field, compress_pkg::OP_IMM);
          end
          default: begin
            // register-register forms are decoded elsewhere, flag them here
            bad = 1'b1;
          end
        endcase
      end
      compress_pkg::KEY_JUMP: begin
        insn = compress_pkg::enc_j(off_jump, compress_pkg::REG_ZERO);
      end
      compress_pkg::KEY_BRANCH_IF_ZERO: begin
        insn = compress_pkg::enc_b(off_branch, compact_base_field, compress_pkg::F3_EQ);
      end
      compress_pkg::KEY_BRANCH_IF_NONZERO: begin
        insn = compress_pkg::enc_b(off_branch, compact_base_field, compress_pkg::F3_NE);
      end
      compress_pkg::KEY_SHIFT_LEFT: begin
        insn = compress_pkg::enc_i({compress_pkg::SHIFT_LOGIC, shamt_left}, rd_full,
                                   compress_pkg::F3_SLL, rd_full, compress_pkg::OP_IMM);
        custom = is_32 && c[12];
        hint = !custom && ((!is_128 && shamt_zero) ||
                           (rd_full == compress_pkg::REG_ZERO));
      end
      compress_pkg::KEY_JUMP_REGISTER: begin
        if (rs2_full != compress_pkg::REG_ZERO) begin
          // move and add forms are not expanded by this block
          bad = 1'b1;
        end else if (!c[12]) begin
          insn = compress_pkg::enc_i(12'h000, rd_full, compress_pkg::F3_ADD,
                                     compress_pkg::REG_ZERO, compress_pkg::OP_JALR);
          bad = (rd_full == compress_pkg::REG_ZERO);
        end else if (rd_full == compress_pkg::REG_ZERO) begin
          insn = compress_pkg::BREAK_WORD;
        end else begin
          insn = compress_pkg::enc_i(12'h000, rd_full, compress_pkg::F3_ADD,
                                     compress_pkg::REG_LINK, compress_pkg::OP_JALR);
        end
      end
      default: begin
        // stack-relative forms and full-width words land here
        bad = 1'b1;
      end
    endcase

    // the all-zero halfword can never expand
    if (c == 16'h0000) begin
      bad = 1'b1;
    end

    // custom space is not implemented, so it traps like reserved space
    if (bad || custom) begin
      insn = 32'h0000_0000;
      hint = 1'b0;
      bad = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result packing and output register

  compress_pkg::expand_result_s next_result;

  // downstream steps pc by two and links pc+2 on the compressed flag
  always_comb begin
    next_result.insn = insn;
    next_result.raw = c;
    next_result.compressed = 1'b1;
    next_result.illegal = bad;
    next_result.hint = hint;
    next_result.custom = custom;
  end

  // one register stage keeps every data output on a flop
  expand_out_stage u_out_stage (
    .clk(clk),
    .rst_n(rst_n_q),
    .ce(ce),
    .in_valid(in_valid),
    .in_result(next_result),
    .out_valid(out_valid),
    .out_result(out_result)
  );

endmodule : compressed_insn_expander

// ==== testbench/expander_asserts.sv ====
`timescale 1ns/10ps
module expander_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fetch side
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [15:0] in_halfword,
  // decoder side
  input wire logic out_valid,
  input compress_pkg::expand_result_s out_result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // taken halfword answers one edge later, flagged compressed and carrying its raw word
  property p_take; ce && in_valid |=> out_valid && out_result.compressed; endproperty
  a_take: assert property (p_take) else $error("no result one edge after take");
  property p_raw; ce && in_valid |=> out_result.raw == $past(in_halfword); endproperty
  a_raw: assert property (p_raw) else $error("raw halfword not passed on");
  property p_idle; ce && !in_valid |=> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("valid without a taken halfword");
  // a stalled enable must freeze both outputs
  property p_hold; !ce |=> $stable(out_result) && $stable(out_valid); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved with enable low");
  property p_zero; ce && in_valid && in_halfword == 16'h0000 |=> out_result.illegal; endproperty
  a_zero: assert property (p_zero) else $error("all-zero halfword not illegal");
  property p_refuse; out_result.illegal |-> out_result.insn == 32'h0 && !out_result.hint;
  endproperty
  a_refuse: assert property (p_refuse) else $error("illegal result still expanded");
  property p_custom; out_result.custom |-> out_result.illegal; endproperty
  a_custom: assert property (p_custom) else $error("custom point not illegal");
  property p_brk; ce && in_valid && in_halfword == 16'h9002 |=>
    out_result.insn == compress_pkg::BREAK_WORD; endproperty
  a_brk: assert property (p_brk) else $error("breakpoint not expanded");
endmodule : expander_asserts

bind compressed_insn_expander expander_asserts i_chk (.clk(clk), .resetn(resetn), .ce(ce),
  .in_valid(in_valid), .in_halfword(in_halfword), .out_valid(out_valid),
  .out_result(out_result));

// ==== testbench/fetch_model.sv ====
`timescale 1ns/10ps
module fetch_model (
  // clock
  input wire logic clk,
  // halfword toward the expander
  output logic in_valid,
  output logic [15:0] in_halfword
);
  initial begin
    in_valid = 1'b0;
    in_halfword = 16'hffff;
  end
  // present one halfword from the next edge on
  task automatic send(input logic [15:0] h);
    @(posedge clk);
    in_valid <= 1'b1;
    in_halfword <= h;
  endtask : send
  // idle bus shows the inverse, so a stale word is never mistaken for fresh data
  task automatic idle();
    @(posedge clk);
    in_valid <= 1'b0;
    in_halfword <= ~in_halfword;
  endtask : idle
endmodule : fetch_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic in_valid;
  logic [15:0] in_halfword;
  logic out_valid;
  compress_pkg::expand_result_s out_result;
  logic wide_valid;
  compress_pkg::expand_result_s wide_result;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  fetch_model i_fetch (.clk(clk), .in_valid(in_valid), .in_halfword(in_halfword));
  compressed_insn_expander i_dut (.clk(clk), .resetn(resetn), .ce(ce), .in_valid(in_valid),
    .in_halfword(in_halfword), .out_valid(out_valid), .out_result(out_result));
  // a second copy on the widest base reaches the doubleword and quadword forms
  compressed_insn_expander #(.base_width(128)) i_dut_wide (.clk(clk), .resetn(resetn),
    .ce(ce), .in_valid(in_valid), .in_halfword(in_halfword), .out_valid(wide_valid),
    .out_result(wide_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [54:0] got, input logic [54:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one halfword through; flags are {illegal, hint, custom}
  task automatic chk(input logic [15:0] h, input logic [31:0] w, input logic [2:0] f);
    i_fetch.send(h);
    i_fetch.idle();
    #1;
    cmp({out_valid, out_result}, {1'b1, w, h, 1'b1, f});
  endtask : chk
  // same stream, judged at the wide copy
  task automatic chk_w(input logic [15:0] h, input logic [31:0] w, input logic [2:0] f);
    i_fetch.send(h);
    i_fetch.idle();
    #1;
    cmp({wide_valid, wide_result}, {1'b1, w, h, 1'b1, f});
  endtask : chk_w
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mem();
    chk(16'h5c7c, {12'h07c, 5'h08, 3'h2, 5'h0f, compress_pkg::OP_LOAD}, 3'h0);
    chk(16'hc0c8, {7'h00, 5'h0a, 5'h09, 3'h2, 5'h04, compress_pkg::OP_STORE}, 3'h0);
    chk(16'h256c, {12'h0c8, 5'h0a, 3'h3, 5'h0b, compress_pkg::OP_LOAD_FP}, 3'h0);
    chk(16'he404, {7'h00, 5'h09, 5'h08, 3'h2, 5'h08, compress_pkg::OP_STORE_FP}, 3'h0);
    chk(16'ha380, {7'h00, 5'h08, 5'h0f, 3'h3, 5'h00, compress_pkg::OP_STORE_FP}, 3'h0);
  endtask : t_mem
  task automatic t_jump();
    chk(16'hbffd, {20'hf_ffff, 5'h00, compress_pkg::OP_JAL}, 3'h0);
    chk(16'h2009, {1'b0, 10'h001, 9'h000, 5'h01, compress_pkg::OP_JAL}, 3'h0);
    chk(16'h8282, {12'h000, 5'h05, 3'h0, 5'h00, compress_pkg::OP_JALR}, 3'h0);
    chk(16'h8002, 32'h0, 3'h4);
    chk(16'h9302, {12'h000, 5'h06, 3'h0, 5'h01, compress_pkg::OP_JALR}, 3'h0);
    chk(16'h9002, compress_pkg::BREAK_WORD, 3'h0);
    chk(16'hd181, {1'b1, 6'h38, 5'h00, 5'h0b, 3'h0, 5'h01, compress_pkg::OP_BRANCH}, 3'h0);
    chk(16'he009, {7'h00, 5'h00, 5'h08, 3'h1, 5'h02, compress_pkg::OP_BRANCH}, 3'h0);
  endtask : t_jump
  task automatic t_const();
    chk(16'h557d, {12'hfff, 5'h00, 3'h0, 5'h0a, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h507d, {12'hfff, 5'h00, 3'h0, 5'h00, compress_pkg::OP_IMM}, 3'h2);
    chk(16'h7181, {20'hf_ffe0, 5'h03, compress_pkg::OP_LUI}, 3'h0);
    chk(16'h6181, 32'h0, 3'h4);
    chk(16'h7101, {12'he00, 5'h02, 3'h0, 5'h02, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h617d, {12'h1f0, 5'h02, 3'h0, 5'h02, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h0044, {12'h004, 5'h02, 3'h0, 5'h09, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h0004, 32'h0, 3'h4);
    chk(16'h0385, {12'h001, 5'h07, 3'h0, 5'h07, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h0381, {12'h000, 5'h07, 3'h0, 5'h07, compress_pkg::OP_IMM}, 3'h2);
  endtask : t_const
  task automatic t_shift();
    chk(16'h027e, {12'h01f, 5'h04, 3'h1, 5'h04, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h127e, 32'h0, 3'h5);
    chk(16'h0202, {12'h000, 5'h04, 3'h1, 5'h04, compress_pkg::OP_IMM}, 3'h2);
    chk(16'h8205, {12'h001, 5'h0c, 3'h5, 5'h0c, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h867d, {7'h20, 5'h1f, 5'h0c, 3'h5, 5'h0c, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h9205, 32'h0, 3'h5);
    chk(16'h9a81, {12'hfe0, 5'h0d, 3'h7, 5'h0d, compress_pkg::OP_IMM}, 3'h0);
    chk(16'h0000, 32'h0, 3'h4);
    chk(16'h8000, 32'h0, 3'h4);
  endtask : t_shift
  task automatic t_wide();
    chk_w(16'h256c, {12'h1c0, 5'h0a, 3'h2, 5'h0b, compress_pkg::OP_MISC_MEM}, 3'h0);
    chk_w(16'h656c, {12'h0c8, 5'h0a, 3'h3, 5'h0b, compress_pkg::OP_LOAD}, 3'h0);
    chk_w(16'ha380, {7'h00, 5'h08, 5'h0f, 3'h4, 5'h00, compress_pkg::OP_STORE}, 3'h0);
    chk_w(16'h2385, {12'h001, 5'h07, 3'h0, 5'h07, compress_pkg::OP_IMM_32}, 3'h0);
    chk_w(16'h0202, {12'h040, 5'h04, 3'h1, 5'h04, compress_pkg::OP_IMM}, 3'h0);
    chk_w(16'h9205, {12'h061, 5'h0c, 3'h5, 5'h0c, compress_pkg::OP_IMM}, 3'h0);
  endtask : t_wide
  // back-to-back halfwords, then a word offered while the enable is low
  task automatic t_flow();
    i_fetch.send(16'h0385);
    i_fetch.send(16'h0044);
    #1;
    cmp({out_valid, out_result.raw}, {1'b1, 16'h0385});
    i_fetch.idle();
    #1;
    cmp({out_valid, out_result.raw}, {1'b1, 16'h0044});
    @(posedge clk);
    ce <= 1'b0;
    i_fetch.send(16'h9a81);
    i_fetch.idle();
    #1;
    cmp({out_valid, out_result.raw}, {1'b0, 16'h0044});
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_flow
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // hang guard: the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_mem();
    t_jump();
    t_const();
    t_shift();
    t_wide();
    t_flow();
    close_out();
  end
endmodule : tb_top
